// ===== design/algo_config_cfg.svh
// Offsets, field positions, reset values and timing counts of the algorithm configuration bank.
`ifndef ALGO_CONFIG_CFG_SVH
`define ALGO_CONFIG_CFG_SVH

// ****************************************************************
// Register indices; the byte address is four times the index
// ****************************************************************
`define ALGO_ONE_INDEX 10'h0A0
`define ALGO_TWO_INDEX 10'h0A2

// ****************************************************************
// Reset values
// ****************************************************************
`define ALGO_ONE_RESET 32'h00000000
`define ALGO_TWO_RESET 32'h00000000

// ****************************************************************
// Field positions
// ****************************************************************
`define PARITY_BIT 31
`define INTERP_BIT 29
`define FILT_MSB 28
`define FILT_LSB 27

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 10
`define FILT_SHORT_NS 200
`define FILT_MID_NS 500
`define FILT_LONG_NS 1000
`define FILT_SHORT_CYC ((`FILT_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_MID_CYC ((`FILT_MID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_LONG_CYC ((`FILT_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== design/algo_config_pkg.sv
// Types shared by the algorithm configuration bank and its speed input filter.
package algo_config_pkg;

    typedef logic [31:0] word_t;

    typedef enum logic [1:0] {
        FILT_OFF,
        FILT_SHORT,
        FILT_MID,
        FILT_LONG
    } filt_sel_t;

endpackage

// ===== design/speed_filt_if.sv
// Carrier between the register bank and the speed input glitch filter.
`timescale 1ns/1ps

interface speed_filt_if;
    logic level;
    algo_config_pkg::filt_sel_t sel;
    logic filtered;

    modport ctrl (
        output level,
        output sel,
        input filtered
    );

    modport filt (
        input level,
        input sel,
        output filtered
    );
endinterface

// ===== design/speed_glitch_filter.sv
// Glitch filter for the synchronised speed command input.
`timescale 1ns/1ps
`include "algo_config_cfg.svh"

module speed_glitch_filter #(
    parameter int CNT_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    speed_filt_if.filt port_if
);

    logic [CNT_W-1:0] cnt;
    logic filtered;
    wire logic [CNT_W-1:0] limit;
    wire logic differs;
    wire logic expired;

    function automatic logic [CNT_W-1:0] limit_of(input algo_config_pkg::filt_sel_t sel);
        logic [CNT_W-1:0] v;
        v = CNT_W'(1);
        case (sel)
            algo_config_pkg::FILT_SHORT: v = CNT_W'(`FILT_SHORT_CYC);
            algo_config_pkg::FILT_MID: v = CNT_W'(`FILT_MID_CYC);
            algo_config_pkg::FILT_LONG: v = CNT_W'(`FILT_LONG_CYC);
            default: v = CNT_W'(1);
        endcase
        return v;
    endfunction

    assign limit = limit_of(port_if.sel);
    assign differs = port_if.level != filtered;
    // A count left past the limit by a switch to a shorter time passes at once,
    // instead of running round the counter first.
    assign expired = cnt >= limit - CNT_W'(1);
    assign port_if.filtered = filtered;

    // A new level must stand for the whole selected time before it passes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
            filtered <= 1'b0;
        end else if (port_if.sel == algo_config_pkg::FILT_OFF) begin
            cnt <= '0;
            filtered <= port_if.level;
        end else if (!differs) begin
            cnt <= '0;
        end else if (expired) begin
            cnt <= '0;
            filtered <= port_if.level;
        end else begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    a_filter_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
        port_if.sel == algo_config_pkg::FILT_OFF |=> filtered == $past(port_if.level))
        else $error("unfiltered mode did not follow the input");

    a_filter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(filtered) && $past(port_if.sel) == algo_config_pkg::FILT_SHORT
        && $past(port_if.sel, 2) == algo_config_pkg::FILT_SHORT
        |-> $past(cnt) == CNT_W'(`FILT_SHORT_CYC - 1))
        else $error("short filter passed a level too early or late");

endmodule

// ===== design/algo_config_regs.sv
// Algorithm configuration registers on a classic Wishbone slave with speed input filtering.
`timescale 1ns/1ps
`include "algo_config_cfg.svh"

module algo_config_regs #(
    parameter int ADR_W = 12,
    parameter int CNT_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic speed_cmd_i,
    output logic speed_cmd_filt_o,
    output logic feedback_angle_interp_enable_o,
    output logic [31:0] algo_config_one_o,
    output logic [31:0] algo_config_two_o
);

    // ****************************************************************
    // Storage and bus state
    // ****************************************************************
    algo_config_pkg::word_t algo_config_one;
    algo_config_pkg::word_t algo_config_two;
    algo_config_pkg::word_t rdat;
    logic ack;

    // ****************************************************************
    // Byte lane merge, shared by both registers
    // ****************************************************************
    function automatic algo_config_pkg::word_t merge(
        input algo_config_pkg::word_t old_w,
        input algo_config_pkg::word_t new_w,
        input logic [3:0] sel
    );
        algo_config_pkg::word_t v;
        v = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                v[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // ****************************************************************
    // Address decoding
    // ****************************************************************
    wire logic [ADR_W-3:0] adr_word;
    wire logic hit_one;
    wire logic hit_two;
    wire logic req;
    wire logic wr_one;
    wire logic wr_two;
    wire logic rd_req;
    wire algo_config_pkg::word_t next_one;
    wire algo_config_pkg::word_t next_two;
    wire algo_config_pkg::word_t rd_sel;

    assign adr_word = wb_adr_i[ADR_W-1:2];
    assign hit_one = adr_word == (ADR_W-2)'(`ALGO_ONE_INDEX);
    assign hit_two = adr_word == (ADR_W-2)'(`ALGO_TWO_INDEX);
    // A cycle is taken only while ack is low, so a request released on its ack writes once.
    assign req = wb_cyc_i && wb_stb_i && !ack;
    assign wr_one = req && wb_we_i && hit_one;
    assign wr_two = req && wb_we_i && hit_two;
    assign rd_req = req && !wb_we_i;
    // Every bit of a selected byte lane, parity included, is stored exactly as written.
    assign next_one = merge(algo_config_one, wb_dat_i, wb_sel_i);
    assign next_two = merge(algo_config_two, wb_dat_i, wb_sel_i);
    // Unmapped words read as zero and still answer, so the master never hangs.
    assign rd_sel = hit_one ? algo_config_one : (hit_two ? algo_config_two : '0);

    // ****************************************************************
    // Bus answer
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rdat <= '0;
        end else begin
            ack <= req;
            if (rd_req) begin
                rdat <= rd_sel;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // The reserved bit 30 has no specified reset; it is cleared to keep simulation clean.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            algo_config_one <= `ALGO_ONE_RESET;
        end else if (wr_one) begin
            algo_config_one <= next_one;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            algo_config_two <= `ALGO_TWO_RESET;
        end else if (wr_two) begin
            algo_config_two <= next_two;
        end
    end

    // ****************************************************************
    // Speed command input synchroniser
    // ****************************************************************
    // Three stages: the first settles metastability, the last two must agree.
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic level;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            level <= 1'b0;
        end else begin
            sync_a <= speed_cmd_i;
            sync_b <= sync_a;
            sync_c <= sync_b;
            if (sync_b == sync_c) begin
                level <= sync_c;
            end
        end
    end

    // ****************************************************************
    // Glitch filter
    // ****************************************************************
    speed_filt_if filt_bus();

    assign filt_bus.level = level;
    assign filt_bus.sel = algo_config_pkg::filt_sel_t'(
        algo_config_one[`FILT_MSB:`FILT_LSB]);

    speed_glitch_filter #(
        .CNT_W(CNT_W)
    ) u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .port_if(filt_bus.filt)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;
    assign speed_cmd_filt_o = filt_bus.filtered;
    assign feedback_angle_interp_enable_o = algo_config_one[`INTERP_BIT];
    assign algo_config_one_o = algo_config_one;
    assign algo_config_two_o = algo_config_two;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (rst_i);

    sequence s_full_write_one;
        wb_cyc_i && wb_stb_i && wb_we_i && !ack && hit_one && wb_sel_i == 4'hF;
    endsequence

    sequence s_full_write_two;
        wb_cyc_i && wb_stb_i && wb_we_i && !ack && hit_two && wb_sel_i == 4'hF;
    endsequence

    sequence s_read_one;
        wb_cyc_i && wb_stb_i && !wb_we_i && !ack && hit_one;
    endsequence

    a_reg_one_write: assert property (
        s_full_write_one ##1 1'b1 |-> algo_config_one == $past(wb_dat_i) && ack)
        else $error("write to first register did not store the data");

    a_reg_one_read: assert property (
        s_read_one ##1 1'b1 |-> wb_dat_o == $past(algo_config_one) && wb_ack_o)
        else $error("read of first register returned wrong data");

    a_reg_two_reset: assert property (disable iff (1'b0)
        rst_i |=> algo_config_two == 32'h00000000)
        else $error("second register not cleared by reset");

    a_reg_two_write: assert property (
        s_full_write_two |=> algo_config_two == $past(wb_dat_i) ##1 !wb_ack_o)
        else $error("second register write or ack release wrong");

    a_filter_select: assert property (
        filt_bus.sel == algo_config_pkg::filt_sel_t'(algo_config_one[28:27]))
        else $error("filter select does not match register field");

    a_interp_enable: assert property (
        s_full_write_one |=> feedback_angle_interp_enable_o == $past(wb_dat_i[29]))
        else $error("interpolation enable did not follow bit 29");

    a_parity_keep: assert property (
        !wr_one && !wr_two |=> $stable(algo_config_one[31]) && $stable(algo_config_two[31]))
        else $error("parity bit changed without a write");

    a_ack_single: assert property (
        ack |=> !ack)
        else $error("ack stood for more than one cycle");

    // ****************************************************************
    // Further bus assertions
    // ****************************************************************
    // A request is taken only while ack is low, so a strobe released on its ack writes once; held longer, it is taken again every second cycle.
    sequence s_take;
        wb_cyc_i && wb_stb_i && !ack;
    endsequence

    sequence s_write_two;
        wb_cyc_i && wb_stb_i && wb_we_i && !ack && hit_two;
    endsequence

    sequence s_read_two;
        wb_cyc_i && wb_stb_i && !wb_we_i && !ack && hit_two;
    endsequence

    sequence s_read_other;
        wb_cyc_i && wb_stb_i && !wb_we_i && !ack && !hit_one && !hit_two;
    endsequence

    sequence s_write_other;
        wb_cyc_i && wb_stb_i && wb_we_i && !ack && !hit_one && !hit_two;
    endsequence

    a_ack_answer: assert property (
        s_take |=> wb_ack_o)
        else $error("taken request was not answered in the next cycle");

    a_reg_two_read: assert property (
        s_read_two |=> wb_dat_o == $past(algo_config_two) && wb_ack_o)
        else $error("read of second register returned wrong data");

    a_unmapped_read: assert property (
        s_read_other |=> wb_dat_o == 32'h00000000 && wb_ack_o)
        else $error("unmapped read did not return zero");

    a_unmapped_drop: assert property (
        s_write_other |=> $stable(algo_config_one) && $stable(algo_config_two))
        else $error("unmapped write changed a register");

    a_read_clean: assert property (
        rd_req |=> $stable(algo_config_one) && $stable(algo_config_two))
        else $error("read changed a register");

    a_dat_hold: assert property (
        !rd_req |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    // ****************************************************************
    // Register and field assertions
    // ****************************************************************
    a_reset_clear: assert property (disable iff (1'b0)
        rst_i |=> algo_config_one == `ALGO_ONE_RESET && !wb_ack_o
            && wb_dat_o == 32'h00000000)
        else $error("reset left the first register, ack or read data set");

    a_reg_one_hold: assert property (
        !wr_one |=> $stable(algo_config_one))
        else $error("first register changed without a write");

    a_reg_two_hold: assert property (
        !wr_two |=> $stable(algo_config_two))
        else $error("second register changed without a write");

    a_interp_hold: assert property (
        !wr_one |=> $stable(feedback_angle_interp_enable_o))
        else $error("interpolation enable changed without a write");

    a_parity_store: assert property (
        s_write_two ##0 wb_sel_i[3] |=> algo_config_two[31] == $past(wb_dat_i[31]))
        else $error("parity bit not stored as written");

    a_lane_keep: assert property (
        s_write_two ##0 !wb_sel_i[3] |=> $stable(algo_config_two[31:24]))
        else $error("unselected top byte lane changed");

    // ****************************************************************
    // Speed input assertions
    // ****************************************************************
    a_sync_agree: assert property (
        $changed(level) |-> $past(sync_b) == $past(sync_c) && level == $past(sync_c))
        else $error("speed level accepted before two stages agreed");

    a_filter_source: assert property (
        $changed(speed_cmd_filt_o) |-> speed_cmd_filt_o == $past(level))
        else $error("filtered speed output took a level never accepted");

endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the algorithm configuration bank and its speed input filter.
`timescale 1ns/1ps
`include "algo_config_cfg.svh"

module tb_top;
    localparam logic [11:0] ONE_ADR = 12'h280;
    localparam logic [11:0] TWO_ADR = 12'h288;
    localparam logic [11:0] BAD_ADR = 12'h284;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic speed_cmd_i = 1'b0;
    logic speed_cmd_filt_o;
    logic feedback_angle_interp_enable_o;
    logic [31:0] algo_config_one_o;
    logic [31:0] algo_config_two_o;
    int n_errors = 0;
    int compares = 0;

    algo_config_regs #(.ADR_W(12), .CNT_W(8)) algo_config_regs_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .speed_cmd_i(speed_cmd_i),
        .speed_cmd_filt_o(speed_cmd_filt_o),
        .feedback_angle_interp_enable_o(feedback_angle_interp_enable_o),
        .algo_config_one_o(algo_config_one_o),
        .algo_config_two_o(algo_config_two_o)
    );

    always #5 clk_i = ~clk_i;

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    // The request stands until the rising edge that samples ack high; the read
    // data is taken at that edge and the request is released there.
    task automatic wb(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            check({31'h0, wb_ack_o}, 32'h00000001);
            close_out();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        logic [31:0] rd;
        wb(1'b1, adr, sel, dat, rd);
    endtask

    task automatic rdchk(input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb(1'b0, adr, 4'hF, 32'h00000000, rd);
        check(rd, exp);
    endtask

    // ****************************************************************
    // Speed input filter: a short glitch is refused in the three filtering modes, a long level passes
    // ****************************************************************
    task automatic run_filter(input logic [1:0] m);
        int lim;
        int lat;
        int rises;
        lim = (m == 2'h0) ? 0 : (m == 2'h1) ? `FILT_SHORT_CYC :
              (m == 2'h2) ? `FILT_MID_CYC : `FILT_LONG_CYC;
        rises = 0;
        wr(ONE_ADR, 4'hF, {3'h0, m, 27'h0000000});
        rdchk(ONE_ADR, {3'h0, m, 27'h0000000});
        if (m != 2'h0) begin
            @(posedge clk_i);
            speed_cmd_i <= 1'b1;
            repeat (lim - 3) @(posedge clk_i);
            speed_cmd_i <= 1'b0;
            repeat (2 * lim) begin
                @(negedge clk_i);
                if (speed_cmd_filt_o !== 1'b0) rises++;
            end
            check(32'(rises), 32'h00000000);
        end
        @(posedge clk_i);
        speed_cmd_i <= 1'b1;
        lat = 0;
        do begin
            @(negedge clk_i);
            lat++;
        end while (speed_cmd_filt_o !== 1'b1 && lat < 300);
        check({31'h0, lat >= lim + 2 && lat <= lim + 8}, 32'h00000001);
        if (speed_cmd_filt_o !== 1'b1) begin
            close_out();
        end
        @(posedge clk_i);
        speed_cmd_i <= 1'b0;
        lat = 0;
        do begin
            @(negedge clk_i);
            lat++;
        end while (speed_cmd_filt_o !== 1'b0 && lat < 300);
        check({31'h0, speed_cmd_filt_o}, 32'h00000000);
        check({31'h0, lat >= lim + 2 && lat <= lim + 8}, 32'h00000001);
        if (speed_cmd_filt_o !== 1'b0) begin
            close_out();
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check(algo_config_one_o, 32'h00000000);
        check({31'h0, speed_cmd_filt_o}, 32'h00000000);
        rdchk(ONE_ADR, 32'h00000000);
        rdchk(TWO_ADR, 32'h00000000);
        wr(ONE_ADR, 4'hF, 32'hFFFFFFFF);
        rdchk(ONE_ADR, 32'hFFFFFFFF);
        check({31'h0, feedback_angle_interp_enable_o}, 32'h00000001);
        wr(ONE_ADR, 4'hF, 32'h80000000);
        rdchk(ONE_ADR, 32'h80000000);
        check({31'h0, feedback_angle_interp_enable_o}, 32'h00000000);
        wr(TWO_ADR, 4'hF, 32'hA5A5A5A5);
        wr(TWO_ADR, 4'h6, 32'h5A5A5A5A);
        rdchk(TWO_ADR, 32'hA55A5AA5);
        check(algo_config_two_o, 32'hA55A5AA5);
        // An unmapped offset must neither store nor disturb its neighbours.
        wr(BAD_ADR, 4'hF, 32'hFFFFFFFF);
        rdchk(BAD_ADR, 32'h00000000);
        rdchk(ONE_ADR, 32'h80000000);
        rdchk(TWO_ADR, 32'hA55A5AA5);
        for (int m = 0; m < 4; m++) begin
            run_filter(2'(m));
        end
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(TWO_ADR, 32'h00000000);
        check(algo_config_one_o, 32'h00000000);
        close_out();
    end
endmodule
